// [src/eeprom_conditional_loader.v]
// Configuration EEPROM controller: conditional download and upload engine
//
// What this block does
// R1: After reset or soft reset, nonzero strap value auto-starts a download with it.
// R2: Condition is five bits; zero means every instruction executes.
// R3: Nonzero condition register field wins; otherwise strapped value is the condition.
// R4: Codes B1 to CF decode as conditions 1 to 31 and tag them.
// R5: Null code B0 empties the tag board; later instructions run unconditionally.
// R6: Condition codes and end code always execute during download.
// R7: Nonzero condition with tags present: execute only if condition is tagged.
// R8: Untagged condition: skip until a condition code tags the current condition.
// R9: Tag board holds many tags; new codes add to it.
// R10: Upload copies condition codes unchanged, no skipping.
// R11: EEPROM stores 2048 bytes addressed by the EEPROM pointer.
// R12: Non-data instruction is one byte; data instruction is N plus four.
// R13: Software bypasses auto load by saving an end code, polling status zero.
// R14: Software stores first setup as condition, data, pause, then upload.
// R15: Later setups start with null code then a new condition code.
// R16: Last stored setup ends with end code instead of pause.
// R17: Software sets condition field, then the self-clearing load bit.
// R18: Part-ID enable appends eight-byte data at its base, update, end.
// R19: Data code 00 to 7F moves value plus one bytes from two-byte address.
// R20: End code in download clears EEPROM pointer and goes idle.
// R21: Checksum mismatch sets fault bit; all matching sets complete bit.
// R22: Pause in upload clears scratch pointer, keeps EEPROM pointer, not stored.
// R23: Skipped data instruction still steps over its bytes without writing.
// R24: Tag board starts empty on every download, except one restarted by soft reset while a B1 to CF code executes.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "eeprom_loader_regs.vh"
module eeprom_conditional_loader (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst_b,
  // Register port
  input wire [11:0] i_bus_addr,
  input wire [7:0] i_bus_wdata,
  input wire i_bus_wr,
  input wire i_bus_rd,
  output wire [7:0] o_bus_rdata,
  // Reset request and straps
  input wire i_soft_reset,
  input wire [4:0] i_condition_strap_pins,
  // Device register map
  output reg o_map_wr,
  output reg o_map_rd,
  output reg [15:0] o_map_addr,
  output reg [7:0] o_map_wdata,
  input wire [7:0] i_map_rdata,
  // Action pulses
  output reg o_io_update,
  output reg o_calibrate,
  output reg o_dist_sync
);

  localparam ST_STRAP = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_D_FETCH = 3'd2;
  localparam ST_D_EXEC = 3'd3;
  localparam ST_U_FETCH = 3'd4;
  localparam ST_U_EXEC = 3'd5;
  localparam ST_U_MAP = 3'd6;
  localparam ST_U_MAPW = 3'd7;

  localparam PH_OPC = 3'd0;
  localparam PH_AHI = 3'd1;
  localparam PH_ALO = 3'd2;
  localparam PH_DATA = 3'd3;
  localparam PH_CSUM = 3'd4;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode helpers
  function is_data_code;
    input [7:0] code;
    begin
      is_data_code = (code <= `CODE_DATA_LAST); // R19
    end
  endfunction

  function is_cond_code;
    input [7:0] code;
    begin
      is_cond_code = (code >= `CODE_COND_NULL) && (code <= `CODE_COND_LAST);
    end
  endfunction

  // Checksum is a running byte sum, same on both directions
  function [7:0] sum_add;
    input [7:0] sum;
    input [7:0] byte_in;
    begin
      sum_add = sum + byte_in;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State
  reg [2:0] state_reg;
  reg [2:0] phase_reg;
  reg [1:0] settle_reg;
  reg [4:0] strap_meta_reg;
  reg [4:0] strap_sync_reg;
  reg [4:0] strap_value_reg;
  reg [4:0] cond_reg;
  reg [4:0] cond_select_reg;
  reg write_enable_reg;
  reg load_complete_reg;
  reg load_fault_reg;
  reg skip_reg;
  reg [10:0] ee_ptr_reg;
  reg [5:0] sp_ptr_reg;
  reg [7:0] len_reg;
  reg [7:0] sum_reg;
  reg [15:0] target_reg;
  reg ee_we_reg;
  reg [10:0] ee_waddr_reg;
  reg [7:0] ee_wdata_reg;
  reg [7:0] rdata_reg;
  reg rd_pad_reg;
  reg tag_clear;
  reg tag_set;

  wire [7:0] ee_rdata;
  wire [7:0] pad_rdata;
  wire exec_now;
  wire idle = (state_reg == ST_IDLE);
  wire uploading = (state_reg >= ST_U_FETCH);
  wire in_pad = (i_bus_addr >= `OFS_SCRATCH_FIRST) && (i_bus_addr <= `OFS_SCRATCH_LAST);
  wire [11:0] pad_ofs = i_bus_addr - `OFS_SCRATCH_FIRST;
  wire pad_wr = i_bus_wr && in_pad;
  wire [5:0] pad_raddr = uploading ? sp_ptr_reg : pad_ofs[5:0];
  wire load_req = i_bus_wr && (i_bus_addr == `OFS_LOAD_TRIGGER) &&
    i_bus_wdata[`BIT_LOAD_GO] && idle;
  wire save_req = i_bus_wr && (i_bus_addr == `OFS_SAVE_TRIGGER) &&
    i_bus_wdata[`BIT_SAVE_GO] && idle && write_enable_reg;
  wire strap_done = (state_reg == ST_STRAP) && (settle_reg == `STRAP_SETTLE_CYCLES);
  wire auto_start = (strap_done && (strap_sync_reg != 5'h00)) ||
    (i_soft_reset && (strap_value_reg != 5'h00)); // R1
  wire [4:0] strap_now = strap_done ? strap_sync_reg : strap_value_reg;
  wire start_load = auto_start || load_req;
  // Soft reset clears the select field on the same edge, so it must not steer
  wire [4:0] start_cond = ((cond_select_reg != 5'h00) && !i_soft_reset) ? cond_select_reg :
    strap_now; // R3
  wire [7:0] byte_in = uploading ? pad_rdata : ee_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and tag board
  cfg_byte_mem #(.AW(`EEPROM_ADDR_WIDTH)) u_eeprom (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_we(ee_we_reg),
    .i_waddr(ee_waddr_reg),
    .i_wdata(ee_wdata_reg),
    .i_raddr(ee_ptr_reg), // R11
    .o_rdata(ee_rdata)
  );

  cfg_byte_mem #(.AW(`SCRATCH_ADDR_WIDTH)) u_scratch (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_we(pad_wr),
    .i_waddr(pad_ofs[5:0]),
    .i_wdata(i_bus_wdata),
    .i_raddr(pad_raddr),
    .o_rdata(pad_rdata)
  );

  condition_tag_board u_tags (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clear(tag_clear),
    .i_tag(tag_set),
    .i_tag_cond(byte_in[4:0] - 5'h10),
    .i_cond(cond_reg),
    .o_exec(exec_now)
  );

  // Download starts and download condition codes touch the board; uploads leave it alone
  always @*
  begin
    tag_clear = start_load; // R24
    tag_set = 1'b0;
    if ((state_reg == ST_D_EXEC) && (phase_reg == PH_OPC) && is_cond_code(ee_rdata))
    begin
      tag_clear = (ee_rdata == `CODE_COND_NULL); // R5 R6
      tag_set = (ee_rdata != `CODE_COND_NULL); // R4 R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser
  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      strap_meta_reg <= 5'h00;
      strap_sync_reg <= 5'h00;
    end
    else
    begin
      strap_meta_reg <= i_condition_strap_pins;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      write_enable_reg <= 1'b0;
      cond_select_reg <= 5'h00;
      rdata_reg <= 8'h00;
      rd_pad_reg <= 1'b0;
    end
    else
    begin
      rd_pad_reg <= i_bus_rd && in_pad;
      if (i_soft_reset)
      begin
        write_enable_reg <= 1'b0;
        cond_select_reg <= 5'h00;
      end
      else if (i_bus_wr && (i_bus_addr == `OFS_WRITE_ENABLE))
      begin
        write_enable_reg <= i_bus_wdata[`BIT_WRITE_ENABLE];
      end
      else if (i_bus_wr && (i_bus_addr == `OFS_CONDITION_SELECT))
      begin
        cond_select_reg <= i_bus_wdata[4:0];
      end
      rdata_reg <= 8'h00;
      if (i_bus_rd)
      begin
        case (i_bus_addr)
          `OFS_EEPROM_STATUS:
          begin
            rdata_reg <= {6'h00, (state_reg >= ST_D_FETCH) && !uploading, uploading}; // R13
          end
          `OFS_LOAD_RESULT:
          begin
            rdata_reg <= {6'h00, load_fault_reg, load_complete_reg};
          end
          `OFS_WRITE_ENABLE:
          begin
            rdata_reg <= {7'h00, write_enable_reg};
          end
          `OFS_CONDITION_SELECT:
          begin
            rdata_reg <= {3'h0, cond_select_reg};
          end
          default:
          begin
            rdata_reg <= 8'h00;
          end
        endcase
      end
    end
  end

  // Scratch pad reads come straight from the pad's own output register
  assign o_bus_rdata = rd_pad_reg ? pad_rdata : rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Controller
  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_STRAP;
      phase_reg <= PH_OPC;
      settle_reg <= 2'd0;
      strap_value_reg <= 5'h00;
      cond_reg <= 5'h00;
      load_complete_reg <= 1'b0;
      load_fault_reg <= 1'b0;
      skip_reg <= 1'b0;
      ee_ptr_reg <= 11'h000;
      sp_ptr_reg <= 6'h00;
      len_reg <= 8'h00;
      sum_reg <= 8'h00;
      target_reg <= 16'h0000;
      ee_we_reg <= 1'b0;
      ee_waddr_reg <= 11'h000;
      ee_wdata_reg <= 8'h00;
      o_map_wr <= 1'b0;
      o_map_rd <= 1'b0;
      o_map_addr <= 16'h0000;
      o_map_wdata <= 8'h00;
      o_io_update <= 1'b0;
      o_calibrate <= 1'b0;
      o_dist_sync <= 1'b0;
    end
    else
    begin
      ee_we_reg <= 1'b0;
      o_map_wr <= 1'b0;
      o_map_rd <= 1'b0;
      o_io_update <= 1'b0;
      o_calibrate <= 1'b0;
      o_dist_sync <= 1'b0;
      if (strap_done)
      begin
        strap_value_reg <= strap_sync_reg;
      end
      if (start_load)
      begin
        // Soft reset aborts any transfer in flight
        cond_reg <= start_cond; // R1 R3
        ee_ptr_reg <= 11'h000;
        phase_reg <= PH_OPC;
        load_complete_reg <= 1'b0;
        load_fault_reg <= 1'b0;
        state_reg <= ST_D_FETCH;
      end
      else if (i_soft_reset || strap_done)
      begin
        state_reg <= ST_IDLE;
      end
      else if (save_req)
      begin
        sp_ptr_reg <= 6'h00;
        phase_reg <= PH_OPC;
        state_reg <= ST_U_FETCH;
      end
      else
      begin
        case (state_reg)
          ST_STRAP:
          begin
            settle_reg <= settle_reg + 2'd1;
          end
          ST_IDLE:
          begin
            state_reg <= ST_IDLE;
          end
          ST_D_FETCH:
          begin
            state_reg <= ST_D_EXEC;
          end
          ST_D_EXEC:
          begin
            state_reg <= ST_D_FETCH;
            ee_ptr_reg <= ee_ptr_reg + 11'h001;
            case (phase_reg)
              PH_OPC:
              begin
                if (ee_rdata == `CODE_END)
                begin
                  ee_ptr_reg <= 11'h000; // R6 R20
                  load_complete_reg <= !load_fault_reg; // R21
                  state_reg <= ST_IDLE;
                end
                else if (is_data_code(ee_rdata))
                begin
                  len_reg <= ee_rdata + 8'h01; // R12 R19
                  skip_reg <= !exec_now; // R7 R8 R23
                  phase_reg <= PH_AHI;
                end
                else if (exec_now && (ee_rdata == `CODE_IO_UPDATE))
                begin
                  o_io_update <= 1'b1; // R7
                end
                else if (exec_now && (ee_rdata == `CODE_CALIBRATE))
                begin
                  o_calibrate <= 1'b1; // R7
                end
                else if (exec_now && (ee_rdata == `CODE_DIST_SYNC))
                begin
                  o_dist_sync <= 1'b1; // R7
                end
              end
              PH_AHI:
              begin
                target_reg[15:8] <= ee_rdata;
                phase_reg <= PH_ALO;
              end
              PH_ALO:
              begin
                target_reg[7:0] <= ee_rdata;
                sum_reg <= 8'h00;
                phase_reg <= PH_DATA;
              end
              PH_DATA:
              begin
                // Skipped blocks still walk every byte to stay aligned
                o_map_wr <= !skip_reg; // R23
                o_map_addr <= target_reg;
                o_map_wdata <= ee_rdata;
                target_reg <= target_reg + 16'h0001;
                sum_reg <= sum_add(sum_reg, ee_rdata);
                len_reg <= len_reg - 8'h01;
                if (len_reg == 8'h01)
                begin
                  phase_reg <= PH_CSUM;
                end
              end
              default:
              begin
                if (!skip_reg && (ee_rdata != sum_reg))
                begin
                  load_fault_reg <= 1'b1; // R21 R23
                end
                phase_reg <= PH_OPC;
              end
            endcase
          end
          ST_U_FETCH:
          begin
            state_reg <= ST_U_EXEC;
          end
          ST_U_EXEC:
          begin
            state_reg <= ST_U_FETCH;
            ee_waddr_reg <= ee_ptr_reg;
            case (phase_reg)
              PH_OPC:
              begin
                sp_ptr_reg <= sp_ptr_reg + 6'h01;
                if (pad_rdata == `CODE_PAUSE)
                begin
                  sp_ptr_reg <= 6'h00; // R22
                  state_reg <= ST_IDLE;
                end
                else
                begin
                  // Condition codes are copied as plain bytes
                  ee_we_reg <= 1'b1; // R10
                  ee_wdata_reg <= pad_rdata;
                  ee_ptr_reg <= ee_ptr_reg + 11'h001;
                  if (pad_rdata == `CODE_END)
                  begin
                    sp_ptr_reg <= 6'h00;
                    ee_ptr_reg <= 11'h000;
                    state_reg <= ST_IDLE;
                  end
                  else if (is_data_code(pad_rdata))
                  begin
                    len_reg <= pad_rdata + 8'h01; // R12
                    phase_reg <= PH_AHI;
                  end
                end
              end
              PH_AHI, PH_ALO:
              begin
                ee_we_reg <= 1'b1; // R12
                ee_wdata_reg <= pad_rdata;
                ee_ptr_reg <= ee_ptr_reg + 11'h001;
                sp_ptr_reg <= sp_ptr_reg + 6'h01;
                sum_reg <= 8'h00;
                if (phase_reg == PH_AHI)
                begin
                  target_reg[15:8] <= pad_rdata;
                  phase_reg <= PH_ALO;
                end
                else
                begin
                  target_reg[7:0] <= pad_rdata;
                  phase_reg <= PH_DATA;
                end
              end
              PH_DATA:
              begin
                o_map_rd <= 1'b1;
                o_map_addr <= target_reg;
                state_reg <= ST_U_MAP;
              end
              default:
              begin
                ee_we_reg <= 1'b1; // R12
                ee_wdata_reg <= sum_reg;
                ee_ptr_reg <= ee_ptr_reg + 11'h001;
                phase_reg <= PH_OPC;
              end
            endcase
          end
          ST_U_MAP:
          begin
            state_reg <= ST_U_MAPW;
          end
          default:
          begin
            ee_we_reg <= 1'b1;
            ee_waddr_reg <= ee_ptr_reg;
            ee_wdata_reg <= i_map_rdata;
            ee_ptr_reg <= ee_ptr_reg + 11'h001;
            sum_reg <= sum_add(sum_reg, i_map_rdata);
            target_reg <= target_reg + 16'h0001;
            len_reg <= len_reg - 8'h01;
            if (len_reg == 8'h01)
            begin
              phase_reg <= PH_CSUM;
            end
            state_reg <= ST_U_EXEC;
          end
        endcase
      end
    end
  end

endmodule // eeprom_conditional_loader

// [common/eeprom_loader_regs.vh]
// Register offsets, field positions, instruction codes and sizes of the configuration loader
`ifndef EEPROM_LOADER_REGS_VH
`define EEPROM_LOADER_REGS_VH

// Register offsets
`define OFS_EEPROM_STATUS 12'h0D00
`define OFS_LOAD_RESULT 12'h0D03
`define OFS_WRITE_ENABLE 12'h0E00
`define OFS_CONDITION_SELECT 12'h0E01
`define OFS_SAVE_TRIGGER 12'h0E02
`define OFS_LOAD_TRIGGER 12'h0E03
`define OFS_SCRATCH_FIRST 12'h0E10
`define OFS_SCRATCH_LAST 12'h0E4F

// Field positions
`define BIT_WRITE_ENABLE 0
`define BIT_SAVE_GO 0
`define BIT_LOAD_GO 1
`define BIT_LOAD_COMPLETE 0
`define BIT_LOAD_FAULT 1
`define BIT_SAVE_BUSY 0
`define BIT_LOAD_BUSY 1
`define CONDITION_WIDTH 5

// Instruction codes
`define CODE_DATA_LAST 8'h7F
`define CODE_IO_UPDATE 8'h80
`define CODE_CALIBRATE 8'hA0
`define CODE_DIST_SYNC 8'hA1
`define CODE_COND_NULL 8'hB0
`define CODE_COND_LAST 8'hCF
`define CODE_PAUSE 8'hFE
`define CODE_END 8'hFF

// Storage sizes
`define EEPROM_ADDR_WIDTH 11
`define SCRATCH_ADDR_WIDTH 6

// Strap settle cycles after reset release
`define STRAP_SETTLE_CYCLES 2'd2

`endif

// [src/cfg_byte_mem.v]
// Byte memory with one write port and a registered read port
`timescale 1ns/1ps
module cfg_byte_mem #(
  parameter AW = 11
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst_b,
  // Write port
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [7:0] i_wdata,
  // Read port
  input wire [AW-1:0] i_raddr,
  output reg [7:0] o_rdata
);

  reg [7:0] mem [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Array has no reset; contents persist like the real storage
  always @(posedge i_core_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule // cfg_byte_mem

// [src/condition_tag_board.v]
// Condition tag board and the execute decision derived from it
`timescale 1ns/1ps
module condition_tag_board (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst_b,
  // Board updates
  input wire i_clear,
  input wire i_tag,
  input wire [4:0] i_tag_cond,
  // Decision
  input wire [4:0] i_cond,
  output wire o_exec
);

  reg [31:1] tags_reg;
  reg [31:1] tags_next;

  ////////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    tags_next = tags_reg;
    if (i_clear)
    begin
      tags_next = 31'h0000_0000; // R5 R24
    end
    else if (i_tag && (i_tag_cond != 5'h00))
    begin
      tags_next[i_tag_cond] = 1'b1; // R4 R9
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tags_reg <= 31'h0000_0000;
    end
    else
    begin
      tags_reg <= tags_next;
    end
  end

  // Null condition or empty board runs everything
  assign o_exec = (i_cond == 5'h00) || (tags_reg == 31'h0000_0000) ||
    tags_reg[i_cond]; // R2 R7 R8

endmodule // condition_tag_board

// [verification/eeprom_loader_checker.sv]
// Port checks for the conditional configuration loader
`timescale 1ns/1ps
`include "eeprom_loader_regs.vh"
module eeprom_loader_checker (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst_b,
  // Register port
  input wire [11:0] i_bus_addr,
  input wire [7:0] i_bus_wdata,
  input wire i_bus_wr,
  input wire i_bus_rd,
  input wire [7:0] o_bus_rdata,
  // Map side
  input wire o_map_wr,
  input wire o_map_rd,
  input wire [15:0] o_map_addr,
  input wire o_io_update
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////
  sequence load_go;
    i_bus_wr && i_bus_addr == `OFS_LOAD_TRIGGER && i_bus_wdata[`BIT_LOAD_GO];
  endsequence
  sequence status_rd;
    i_bus_rd && i_bus_addr == `OFS_EEPROM_STATUS;
  endsequence
  AST_LOAD_BUSY: assert property (load_go ##1 status_rd |=> o_bus_rdata[`BIT_LOAD_BUSY])
    else $error("load not busy");
  AST_LOAD_CLR: assert property (i_bus_rd && i_bus_addr == `OFS_LOAD_TRIGGER |=> !o_bus_rdata[1])
    else $error("load bit stuck");
  AST_SAVE_CLR: assert property (i_bus_rd && i_bus_addr == `OFS_SAVE_TRIGGER |=> !o_bus_rdata[0])
    else $error("save bit stuck");
  AST_UNMAPPED: assert property (i_bus_rd && i_bus_addr > 12'h0E4F |=> o_bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ADDR_STEP: assert property (o_map_wr ##2 o_map_wr |-> o_map_addr == $past(o_map_addr, 2) + 16'h0001)
    else $error("map address not stepping");
  AST_WR_PULSE: assert property (o_map_wr |=> !o_map_wr)
    else $error("map write too long");
  AST_RD_PULSE: assert property (o_map_rd |=> !o_map_rd)
    else $error("map read too long");
  AST_WR_RD: assert property (!(o_map_wr && o_map_rd))
    else $error("map read and write together");
  AST_IO_PULSE: assert property (o_io_update |=> !o_io_update)
    else $error("update pulse too long");
endmodule // eeprom_loader_checker

// [verification/reg_map_model.sv]
// Device register map seen by the loader
`timescale 1ns/1ps
module reg_map_model (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst_b,
  // Map access
  input wire i_map_wr,
  input wire i_map_rd,
  input wire [15:0] i_map_addr,
  input wire [7:0] i_map_wdata,
  output reg [7:0] o_map_rdata
);
  reg [7:0] mem [0:255];
  integer k;
  initial for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'h5A;
  ////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_map_rdata <= 8'h00;
    else
    begin
      // Data only valid one cycle; inverted after so late samples show up
      if (i_map_rd)
        o_map_rdata <= mem[i_map_addr[7:0]];
      else
        o_map_rdata <= ~o_map_rdata;
      if (i_map_wr)
        mem[i_map_addr[7:0]] <= i_map_wdata;
    end
  end
endmodule // reg_map_model

// [verification/test_eeprom_conditional_loader.sv]
// Self-checking bench for the conditional configuration loader
`timescale 1ns/1ps
`include "eeprom_loader_regs.vh"
module test_eeprom_conditional_loader;
  reg i_core_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg [11:0] i_bus_addr = 12'h000;
  reg [7:0] i_bus_wdata = 8'h00;
  reg i_bus_wr = 1'b0;
  reg i_bus_rd = 1'b0;
  reg i_soft_reset = 1'b0;
  reg [4:0] i_condition_strap_pins = 5'h00;
  wire [7:0] o_bus_rdata;
  wire [7:0] map_rdata;
  wire [7:0] o_map_wdata;
  wire [15:0] o_map_addr;
  wire o_map_wr;
  wire o_map_rd;
  wire o_io_update;
  wire o_calibrate;
  wire o_dist_sync;
  reg [7:0] rv;
  reg [15:0] last_addr = 16'h0000;
  reg [7:0] pad [0:21];
  integer n_fail = 0;
  integer samples_checked = 0;
  integer n_wr = 0;
  integer n_io = 0;
  integer k;
  always #5 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////////
  eeprom_conditional_loader i_eeprom_conditional_loader (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
    .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .o_bus_rdata(o_bus_rdata),
    .i_soft_reset(i_soft_reset), .i_condition_strap_pins(i_condition_strap_pins),
    .o_map_wr(o_map_wr), .o_map_rd(o_map_rd), .o_map_addr(o_map_addr),
    .o_map_wdata(o_map_wdata), .i_map_rdata(map_rdata), .o_io_update(o_io_update),
    .o_calibrate(o_calibrate), .o_dist_sync(o_dist_sync));
  reg_map_model i_reg_map_model (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_map_wr(o_map_wr), .i_map_rd(o_map_rd), .i_map_addr(o_map_addr),
    .i_map_wdata(o_map_wdata), .o_map_rdata(map_rdata));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input [15:0] exp, input [15:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("BAD %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits an edge first so two writes never retoggle the strobe at once
  task wr(input [11:0] a, input [7:0] d);
    @(posedge i_core_clk);
    i_bus_addr <= a;
    i_bus_wdata <= d;
    i_bus_wr <= 1'b1;
    @(posedge i_core_clk);
    i_bus_wr <= 1'b0;
  endtask
  task rd(input [11:0] a);
    i_bus_addr <= a;
    i_bus_rd <= 1'b1;
    @(posedge i_core_clk);
    i_bus_rd <= 1'b0;
    #1 rv = o_bus_rdata;
    @(posedge i_core_clk);
  endtask
  task wait_idle;
    rv = 8'hFF;
    for (k = 0; k < 3000 && rv !== 8'h00; k = k + 1)
      rd(`OFS_EEPROM_STATUS);
    if (rv !== 8'h00)
    begin
      n_fail = n_fail + 1;
      $display("BAD status expected 00 seen %h", rv);
      report_and_stop;
    end
  endtask
  task load(input [7:0] c);
    n_wr = 0;
    n_io = 0;
    wr(`OFS_CONDITION_SELECT, c);
    wr(`OFS_LOAD_TRIGGER, 8'h02);
    rd(`OFS_EEPROM_STATUS);
  endtask
  task expect_load(input [15:0] en, input [15:0] ea, input [15:0] ei);
    wait_idle;
    chk("writes", en, n_wr[15:0]);
    chk("last", ea, last_addr);
    chk("actions", ei, n_io[15:0]);
  endtask
  task soft_rst;
    n_wr = 0;
    n_io = 0;
    i_soft_reset <= 1'b1;
    @(posedge i_core_clk);
    i_soft_reset <= 1'b0;
    repeat (5) @(posedge i_core_clk);
  endtask
  always @(posedge i_core_clk)
  begin
    // One hex digit per action: sync, calibrate, update
    n_io = n_io + {o_dist_sync, 3'h0, o_calibrate, 3'h0, o_io_update};
    if (o_map_wr)
    begin
      n_wr = n_wr + 1;
      last_addr = o_map_addr;
      chk("map data", {8'h00, o_map_addr[7:0] ^ 8'h5A}, {8'h00, o_map_wdata});
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {pad[0], pad[1], pad[2], pad[3], pad[4], pad[5], pad[6]} =
      {8'h00, 8'h00, 8'h10, 8'hB1, 8'h01, 8'h00, 8'h20};
    {pad[7], pad[8], pad[9], pad[10], pad[11], pad[12]} =
      {8'h80, 8'hB0, 8'h00, 8'h00, 8'h30, 8'hFE};
    {pad[13], pad[14], pad[15], pad[16], pad[17]} = {8'hB0, 8'hB2, 8'hA0, 8'hA1, 8'h07};
    {pad[18], pad[19], pad[20], pad[21]} = {8'h0C, 8'h00, 8'h80, 8'hFF};
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    rd(`OFS_EEPROM_STATUS);
    chk("idle", 16'h0000, rv);
    rd(`OFS_CONDITION_SELECT);
    chk("select", 16'h0000, rv);
    rd(12'h0F00);
    chk("unmapped", 16'h0000, rv);
    for (k = 0; k < 13; k = k + 1)
      wr(`OFS_SCRATCH_FIRST + k, pad[k]);
    rd(`OFS_SCRATCH_FIRST + 12'h003);
    chk("pad", 16'h00B1, rv);
    wr(`OFS_WRITE_ENABLE, 8'h01);
    wr(`OFS_SAVE_TRIGGER, 8'h01);
    rd(`OFS_SAVE_TRIGGER);
    wait_idle;
    // Second setup lands after the pause, ends with part-ID block and end code
    for (k = 13; k < 22; k = k + 1)
      wr(`OFS_SCRATCH_FIRST + k - 13, pad[k]);
    wr(`OFS_SAVE_TRIGGER, 8'h01);
    wait_idle;
    load(8'h02);
    expect_load(16'h000A, 16'h0C07, 16'h0111);
    load(8'h01);
    rd(`OFS_LOAD_TRIGGER);
    chk("load bit", 16'h0000, rv);
    expect_load(16'h0004, 16'h0030, 16'h0001);
    load(8'h00);
    expect_load(16'h000C, 16'h0C07, 16'h0112);
    rd(`OFS_LOAD_RESULT);
    chk("result", 16'h0001, rv);
    // Hard reset with a nonzero strap runs the stored setup
    i_condition_strap_pins <= 5'h02;
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    n_wr = 0;
    n_io = 0;
    i_rst_b <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    expect_load(16'h000A, 16'h0C07, 16'h0111);
    load(8'h01);
    expect_load(16'h0004, 16'h0030, 16'h0001);
    soft_rst;
    expect_load(16'h000A, 16'h0C07, 16'h0111);
    rd(`OFS_CONDITION_SELECT);
    chk("select", 16'h0000, rv);
    // Bypass: an end code saved at the first byte stops the auto load
    wr(`OFS_SCRATCH_FIRST, 8'hFF);
    wr(`OFS_WRITE_ENABLE, 8'h01);
    wr(`OFS_SAVE_TRIGGER, 8'h01);
    wait_idle;
    soft_rst;
    expect_load(16'h0000, 16'h0C07, 16'h0000);
    report_and_stop;
  end
endmodule // test_eeprom_conditional_loader

bind eeprom_conditional_loader eeprom_loader_checker i_eeprom_loader_checker (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus_addr(i_bus_addr),
  .i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
  .o_bus_rdata(o_bus_rdata), .o_map_wr(o_map_wr), .o_map_rd(o_map_rd),
  .o_map_addr(o_map_addr), .o_io_update(o_io_update));
